//--- dat_activate_refresh_timing.v
/*
  Command decode and bank timing supervision for an eight-bank DRAM die.
  Assumes command/address pins arrive from the controller's clock domain and
  are resynchronised here; commands must be held stable for several cycles.
*/
`timescale 1ns/1ps
`include "dat_defs.vh"
module dat_activate_refresh_timing #(
  parameter ROW_W    = 15,
  parameter TW       = 8,
  parameter RL3_SUP  = 1'b0,
  parameter WLB_SUP  = 1'b0
) (
  input  wire             i_mclk,
  input  wire             i_resetn,
  input  wire             i_cs_n,
  input  wire [3:0]       i_ca,
  input  wire             i_ab,
  input  wire [2:0]       i_ba,
  input  wire [ROW_W-1:0] i_row,
  output reg              o_act,
  output reg  [2:0]       o_act_bank,
  output reg  [ROW_W-1:0] o_act_row,
  output reg              o_pre,
  output reg              o_refab,
  output reg              o_refpb,
  output reg              o_rw,
  output wire [7:0]       o_bank_open,
  output wire [7:0]       o_bank_rw_ready,
  output reg              o_timing_viol,
  output wire [7:0]       o_mr0
);
  localparam integer  TRCD_N   = `DAT_CYC(`DAT_TRCD_NS);
  localparam integer  TRAS_N   = `DAT_CYC(`DAT_TRAS_NS);
  localparam integer  TRPPB_N  = `DAT_CYC(`DAT_TRPPB_NS);
  localparam integer  TRPAB_N  = `DAT_CYC(`DAT_TRPAB_NS);
  localparam integer  TRC_N    = `DAT_CYC(`DAT_TRC_NS);
  localparam integer  TRRD_N   = `DAT_CYC(`DAT_TRRD_NS);
  localparam integer  TFAW_N   = `DAT_CYC(`DAT_TFAW_NS);
  localparam integer  TRFCAB_N = `DAT_CYC(`DAT_TRFCAB_NS);
  localparam integer  TRFCPB_N = `DAT_CYC(`DAT_TRFCPB_NS);
  // Counts are cut to the timer width on purpose
  localparam [TW-1:0] TRCD   = TRCD_N[TW-1:0];
  localparam [TW-1:0] TRAS   = TRAS_N[TW-1:0];
  localparam [TW-1:0] TRPPB  = TRPPB_N[TW-1:0];
  localparam [TW-1:0] TRPAB  = TRPAB_N[TW-1:0];
  localparam [TW-1:0] TRC    = TRC_N[TW-1:0];
  localparam [TW-1:0] TRRD   = TRRD_N[TW-1:0];
  localparam [TW-1:0] TFAW   = TFAW_N[TW-1:0];
  localparam [TW-1:0] TRFCAB = TRFCAB_N[TW-1:0];
  localparam [TW-1:0] TRFCPB = TRFCPB_N[TW-1:0];

  // ----------------------------------------------------------------
  // Pin resynchronisation
  // ----------------------------------------------------------------
  localparam PW = 5 + 1 + 3 + ROW_W;
  reg  [PW-1:0] s1;
  reg  [PW-1:0] s2;
  reg  [PW-1:0] s3;
  reg  [PW-1:0] pins;
  reg           was_idle;
  wire [PW-1:0] raw = {i_cs_n, i_ca, i_ab, i_ba, i_row};
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1   <= {PW{1'b1}};
      s2   <= {PW{1'b1}};
      s3   <= {PW{1'b1}};
      pins <= {PW{1'b1}};
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      // Only a settled pattern is taken, so skewed pins never decode
      if (s2 == s3)
        pins <= s3;
    end
  end
  wire             p_cs_n = pins[PW-1];
  wire [3:0]       p_ca   = pins[PW-2:PW-5];
  wire             p_ab   = pins[PW-6];
  wire [2:0]       p_ba   = pins[PW-7:PW-9];
  wire [ROW_W-1:0] p_row  = pins[ROW_W-1:0];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // activate pattern
  wire d_act   = !p_cs_n && !p_ca[0] && p_ca[1];
  wire d_pre   = !p_cs_n && p_ca[0] && p_ca[1] && !p_ca[2] && p_ca[3];
  wire d_ref   = !p_cs_n && !p_ca[0] && !p_ca[1] && p_ca[2];
  wire d_rw    = !p_cs_n && p_ca[0] && !p_ca[1];
  wire any_cmd = d_act | d_pre | d_ref | d_rw;
  // One pulse per command: a held pattern counts once until deselect
  wire fire    = any_cmd && was_idle;
  wire f_act   = fire && d_act;
  wire f_pre   = fire && d_pre;
  wire f_refab = fire && d_ref && p_ca[3];
  wire f_refpb = fire && d_ref && !p_ca[3];
  wire f_rw    = fire && d_rw;

  function [7:0] dat_onehot;
    input [2:0] b;
    begin
      dat_onehot = 8'h01 << b;
    end
  endfunction

  wire [7:0] bank_sel = dat_onehot(p_ba);

  // ----------------------------------------------------------------
  // Per-bank timers
  // ----------------------------------------------------------------
  wire [7:0] bank_viol;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bank
      dat_bank_timer #(.W(TW)) u_bank (
        .i_mclk     (i_mclk),
        .i_resetn   (i_resetn),
        .i_act      (f_act && bank_sel[g]),
        .i_pre      (f_pre && !p_ab && bank_sel[g]),
        .i_pre_all  (f_pre && p_ab),
        .i_refpb    (f_refpb && bank_sel[g]),
        .i_access   (f_rw && bank_sel[g]),
        .i_trcd     (TRCD),
        .i_tras     (TRAS),
        .i_trppb    (TRPPB),
        .i_trpab    (TRPAB),
        .i_trc      (TRC),
        .i_trfcpb   (TRFCPB),
        .o_open     (o_bank_open[g]),
        .o_rw_ready (o_bank_rw_ready[g]),
        .o_viol     (bank_viol[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shared activate spacing, four-activate window, refresh recovery
  // ----------------------------------------------------------------
  reg  [TW-1:0] rrd_cnt;
  reg  [TW-1:0] rfc_cnt;
  reg  [TW-1:0] faw_age [0:3];
  reg  [2:0]    faw_live;
  wire          faw_evt = f_act | f_refpb;
  integer       k;
  integer       j;
  always @* begin
    faw_live = 3'h0;
    for (j = 0; j < 4; j = j + 1)
      if (faw_age[j] != {TW{1'b0}})
        faw_live = faw_live + 3'h1;
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      was_idle      <= 1'b1;
      rrd_cnt       <= {TW{1'b0}};
      rfc_cnt       <= {TW{1'b0}};
      for (k = 0; k < 4; k = k + 1)
        faw_age[k] <= {TW{1'b0}};
      o_act         <= 1'b0;
      o_act_bank    <= 3'h0;
      o_act_row     <= {ROW_W{1'b0}};
      o_pre         <= 1'b0;
      o_refab       <= 1'b0;
      o_refpb       <= 1'b0;
      o_rw          <= 1'b0;
      o_timing_viol <= 1'b0;
    end else begin
      was_idle <= !any_cmd;
      o_act    <= f_act;
      o_pre    <= f_pre;
      o_refab  <= f_refab;
      o_refpb  <= f_refpb;
      o_rw     <= f_rw;
      if (f_act) begin
        o_act_bank <= p_ba;
        o_act_row  <= p_row;
      end
      if (rrd_cnt != {TW{1'b0}}) rrd_cnt <= rrd_cnt - 1'b1;
      if (rfc_cnt != {TW{1'b0}}) rfc_cnt <= rfc_cnt - 1'b1;
      for (k = 0; k < 4; k = k + 1)
        if (faw_age[k] != {TW{1'b0}})
          faw_age[k] <= faw_age[k] - 1'b1;
      if (faw_evt) begin
        faw_age[0] <= TFAW - 1'b1;
        for (k = 1; k < 4; k = k + 1)
          faw_age[k] <= (faw_age[k-1] != {TW{1'b0}}) ? faw_age[k-1] - 1'b1 : {TW{1'b0}};
      end
      if (f_act)
        rrd_cnt <= TRRD - 1'b1;
      if (f_refab)
        rfc_cnt <= TRFCAB - 1'b1;
      o_timing_viol <= (|bank_viol)
                     | (f_act && rrd_cnt != {TW{1'b0}})
                     | (faw_evt && faw_live >= 3'h4)
                     | (fire && rfc_cnt != {TW{1'b0}})
                     | (f_refab && |o_bank_open);
    end
  end

  // ----------------------------------------------------------------
  // Mode register 0 capability bits
  // ----------------------------------------------------------------
  // optional latency support
  assign o_mr0 = {RL3_SUP[0], WLB_SUP[0], 6'h00};
endmodule // dat_activate_refresh_timing

//--- dat_defs.vh
/*
  Timing and encoding constants for the DRAM activate/refresh timing block.
  Assumes a 50 MHz core clock; the command bus is sampled on that clock.
*/
`ifndef DAT_DEFS_VH
`define DAT_DEFS_VH
`define DAT_CLK_MHZ        50
`define DAT_NUM_BANKS      8
`define DAT_FAW_MAX_ACT    4
`define DAT_TRCD_NS        18
`define DAT_TRAS_NS        42
`define DAT_TRPPB_NS       18
`define DAT_TRPAB_NS       21
`define DAT_TRC_NS         60
`define DAT_TRRD_NS        10
`define DAT_TFAW_NS        50
`define DAT_TRFCAB_NS      210
`define DAT_TRFCPB_NS      90
`define DAT_CYC(ns)        (((ns) * `DAT_CLK_MHZ + 999) / 1000)
`define DAT_MR0_RL3_BIT    7
`define DAT_MR0_WLB_BIT    6
`endif

//--- dat_bank_timer.v
/*
  Per-bank state and timers: open/closed, tRCD, tRAS, tRP and tRC tracking.
  Assumes one-cycle command pulses already decoded on the core clock.
*/
`timescale 1ns/1ps
`include "dat_defs.vh"
module dat_bank_timer #(
  parameter W = 8
) (
  input  wire         i_mclk,
  input  wire         i_resetn,
  input  wire         i_act,
  input  wire         i_pre,
  input  wire         i_pre_all,
  input  wire         i_refpb,
  input  wire         i_access,
  input  wire [W-1:0] i_trcd,
  input  wire [W-1:0] i_tras,
  input  wire [W-1:0] i_trppb,
  input  wire [W-1:0] i_trpab,
  input  wire [W-1:0] i_trc,
  input  wire [W-1:0] i_trfcpb,
  output reg          o_open,
  output wire         o_rw_ready,
  output reg          o_viol
);
  reg [W-1:0] rcd_cnt;
  reg [W-1:0] ras_cnt;
  reg [W-1:0] rp_cnt;
  reg [W-1:0] rc_cnt;
  assign o_rw_ready = o_open && (rcd_cnt == {W{1'b0}});
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_open  <= 1'b0;
      rcd_cnt <= {W{1'b0}};
      ras_cnt <= {W{1'b0}};
      rp_cnt  <= {W{1'b0}};
      rc_cnt  <= {W{1'b0}};
      o_viol  <= 1'b0;
    end else begin
      o_viol <= 1'b0;
      if (rcd_cnt != {W{1'b0}}) rcd_cnt <= rcd_cnt - 1'b1;
      if (ras_cnt != {W{1'b0}}) ras_cnt <= ras_cnt - 1'b1;
      if (rp_cnt != {W{1'b0}})  rp_cnt  <= rp_cnt - 1'b1;
      if (rc_cnt != {W{1'b0}})  rc_cnt  <= rc_cnt - 1'b1;
      if (i_act) begin
        if (o_open || rp_cnt != {W{1'b0}} || rc_cnt != {W{1'b0}})
          o_viol <= 1'b1;
        o_open  <= 1'b1;
        rcd_cnt <= i_trcd - 1'b1;
        ras_cnt <= i_tras - 1'b1;
        rc_cnt  <= i_trc - 1'b1;
      end else if (i_pre || i_pre_all) begin
        if (o_open && ras_cnt != {W{1'b0}})
          o_viol <= 1'b1;
        o_open <= 1'b0;
        rp_cnt <= (i_pre_all ? i_trpab : i_trppb) - 1'b1;
      end else if (i_refpb) begin
        if (o_open || rp_cnt != {W{1'b0}})
          o_viol <= 1'b1;
        rp_cnt <= i_trfcpb - 1'b1;
      end
      // access needs open bank past tRCD
      if (i_access && !(o_open && rcd_cnt == {W{1'b0}}))
        o_viol <= 1'b1;
    end
  end
endmodule // dat_bank_timer

//--- dat_art_chk.sv
/*
  Port checker for the activate/refresh timing block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module dat_art_chk #(
  parameter RL3_SUP = 1'b0,
  parameter WLB_SUP = 1'b0
) (
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic       i_cs_n,
  input wire logic [3:0] i_ca,
  input wire logic       i_ab,
  input wire logic       o_act,
  input wire logic [2:0] o_act_bank,
  input wire logic       o_pre,
  input wire logic       o_refab,
  input wire logic       o_refpb,
  input wire logic       o_rw,
  input wire logic [7:0] o_bank_open,
  input wire logic [7:0] o_bank_rw_ready,
  input wire logic [7:0] o_mr0
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------
  // Decode: pins sampled mid-hold, 3 back
  // ----------------------------------------
  act_decode_a: assert property (o_act |-> !$past(i_cs_n, 3) && $past(i_ca[1:0], 3) == 2'b10)
    else $error("activate without its pattern");
  pre_decode_a: assert property (o_pre |-> !$past(i_cs_n, 3) && $past(i_ca, 3) == 4'hB)
    else $error("precharge without its pattern");
  rw_decode_a: assert property (o_rw |-> !$past(i_cs_n, 3) && $past(i_ca[1:0], 3) == 2'b01)
    else $error("access without its pattern");
  refab_decode_a: assert property (o_refab |-> $past(i_ca, 3) == 4'hC)
    else $error("all-bank refresh without its pattern");
  refpb_decode_a: assert property (o_refpb |-> $past(i_ca, 3) == 4'h4)
    else $error("per-bank refresh without its pattern");
  pulse_onehot_a: assert property ($onehot0({o_act, o_pre, o_refab, o_refpb, o_rw}))
    else $error("two commands at once");
  act_single_a: assert property (o_act |=> !o_act)
    else $error("activate pulse too long");
  act_opens_a: assert property (o_act |=> o_bank_open[$past(o_act_bank)])
    else $error("activated bank not open");
  pre_all_a: assert property (o_pre && $past(i_ab, 3) |=> o_bank_open == 8'h00)
    else $error("precharge-all left a bank open");
  ready_open_a: assert property ((o_bank_rw_ready & ~o_bank_open) == 8'h00)
    else $error("closed bank ready for access");
  mr0_fixed_a: assert property (o_mr0 == {RL3_SUP, WLB_SUP, 6'h00})
    else $error("mode register 0 wrong");
endmodule // dat_art_chk

bind dat_activate_refresh_timing dat_art_chk #(.RL3_SUP(RL3_SUP), .WLB_SUP(WLB_SUP)) dat_art_chk_i (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_ca(i_ca), .i_ab(i_ab),
  .o_act(o_act), .o_act_bank(o_act_bank), .o_pre(o_pre), .o_refab(o_refab),
  .o_refpb(o_refpb), .o_rw(o_rw), .o_bank_open(o_bank_open),
  .o_bank_rw_ready(o_bank_rw_ready), .o_mr0(o_mr0));

//--- dat_ctrl_model.sv
/*
  Behavioural memory controller driving the command pins.
  Assumes the caller is the testbench; pins change on the falling edge.
*/
`timescale 1ns/1ps
module dat_ctrl_model #(
  parameter ROW_W = 15
) (
  input  wire logic             i_mclk,
  output logic                  o_cs_n,
  output logic [3:0]            o_ca,
  output logic                  o_ab,
  output logic [2:0]            o_ba,
  output logic [ROW_W-1:0]      o_row
);
  initial {o_cs_n, o_ca, o_ab, o_ba, o_row} = {1'b1, {(ROW_W + 8){1'b0}}};
  // Callers space commands by the idle count; four idle clocks outlast every
  // window but refresh recovery, and a short gap is chosen only to provoke it
  // Runs are far shorter than any refresh window, so the refresh rate is met
  task automatic cmd(input logic [3:0] ca, input logic ab, input logic [2:0] ba,
                     input logic [ROW_W-1:0] row, input int idle);
    @(negedge i_mclk);
    {o_cs_n, o_ca, o_ab, o_ba, o_row} = {1'b0, ca, ab, ba, row};
    repeat (4) @(negedge i_mclk);
    // Released pins show the inverse, never a stale copy
    {o_cs_n, o_ca, o_ab, o_ba, o_row} = {1'b1, ~ca, ~ab, ~ba, ~row};
    repeat (idle) @(negedge i_mclk);
  endtask
endmodule // dat_ctrl_model

//--- dat_activate_refresh_timing_tb_top.sv
/*
  Self-checking bench for the activate/refresh timing block.
  Assumes the controller model drives all command pins.
*/
`timescale 1ns/1ps
module dat_activate_refresh_timing_tb_top;
  logic              i_mclk;
  logic              i_resetn;
  wire               cs_n, ab, o_act, o_pre, o_refab, o_refpb, o_rw, o_timing_viol;
  wire  [3:0]        ca;
  wire  [2:0]        ba, o_act_bank;
  wire  [14:0]       row, o_act_row;
  wire  [7:0]        o_bank_open, o_bank_rw_ready, o_mr0;
  logic [23:0]       exp_q[$];
  logic [23:0]       seen;
  logic [7:0]        open_exp;
  logic [14:0]       r;
  logic [2:0]        pb;
  int                fail_count, checks_done;

  dat_ctrl_model dat_ctrl_model_i (.i_mclk(i_mclk), .o_cs_n(cs_n),
    .o_ca(ca), .o_ab(ab), .o_ba(ba), .o_row(row));
  dat_activate_refresh_timing #(.RL3_SUP(1'b1))
    dat_activate_refresh_timing_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_cs_n(cs_n),
    .i_ca(ca), .i_ab(ab), .i_ba(ba), .i_row(row), .o_act(o_act), .o_act_bank(o_act_bank),
    .o_act_row(o_act_row), .o_pre(o_pre), .o_refab(o_refab), .o_refpb(o_refpb), .o_rw(o_rw),
    .o_bank_open(o_bank_open), .o_bank_rw_ready(o_bank_rw_ready),
    .o_timing_viol(o_timing_viol), .o_mr0(o_mr0));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Kind bits: act, pre, refab, refpb, rw, viol; then bank and row of an activate
  task automatic issue(input logic [3:0] c, input logic a, input logic [2:0] b,
                       input logic [14:0] rw, input int idle, input logic [23:0] e);
    exp_q.push_back(e);
    dat_ctrl_model_i.cmd(c, a, b, rw, idle);
  endtask

  task automatic chk_open;
    chk("bank_open", {16'h0, open_exp}, {16'h0, o_bank_open});
    chk("rw_ready", {16'h0, open_exp}, {16'h0, o_bank_rw_ready});
  endtask

  // Outputs are looked at mid-cycle, away from the edge that launches them
  always @(negedge i_mclk) begin
    seen = {o_act, o_pre, o_refab, o_refpb, o_rw, o_timing_viol,
            o_act ? {o_act_bank, o_act_row} : 18'h0};
    if (|seen[23:18] === 1'b1)
      chk("pulse", exp_q.size() > 0 ? exp_q.pop_front() : 24'h0, seen);
  end

  initial begin
    i_resetn = 1'b0;
    open_exp = 8'h00;
    void'($urandom(32'h394F135A));
    repeat (16) @(posedge i_mclk);
    @(negedge i_mclk) i_resetn = 1'b1;
    chk("mr0", 24'h80, {16'h0, o_mr0});
    for (int b = 0; b < 8; b++) begin
      r = 15'($urandom);
      issue(4'h2, 1'b0, 3'(b), r, 4, {6'h20, 3'(b), r});
      open_exp[b] = 1'b1;
      chk_open();
    end
    issue(4'h5, 1'b0, 3'h2, 15'h0, 4, 24'h080000);
    issue(4'h1, 1'b0, 3'h5, 15'h0, 4, 24'h080000);
    pb = 3'($urandom);
    issue(4'hB, 1'b0, pb, 15'h0, 4, 24'h400000);
    open_exp[pb] = 1'b0;
    chk_open();
    // Refreshing all banks with rows open is flagged in the cycle of its own pulse
    issue(4'hC, 1'b0, 3'h0, 15'h0, 8, 24'h240000);
    issue(4'hB, 1'b1, 3'($urandom), 15'h0, 4, 24'h400000);
    open_exp = 8'h00;
    chk_open();
    issue(4'h4, 1'b0, 3'h3, 15'h0, 4, 24'h100000);
    issue(4'hC, 1'b1, 3'h0, 15'h0, 8, 24'h200000);
    r = 15'($urandom);
    issue(4'h2, 1'b0, 3'h3, r, 4, {6'h20, 3'h3, r});
    open_exp[3] = 1'b1;
    chk_open();
    // Bank-level faults are flagged one cycle after the offending pulse
    exp_q.push_back({6'h20, 3'h3, r});
    issue(4'h2, 1'b0, 3'h3, r, 4, 24'h040000);
    exp_q.push_back(24'h080000);
    issue(4'h5, 1'b0, 3'h6, 15'h0, 8, 24'h040000);
    chk_open();
    issue(4'hB, 1'b1, 3'h0, 15'h0, 4, 24'h400000);
    open_exp = 8'h00;
    // A short gap after an all-bank refresh breaks its recovery time
    issue(4'hC, 1'b0, 3'h0, 15'h0, 2, 24'h200000);
    r = 15'($urandom);
    issue(4'h2, 1'b0, 3'h1, r, 4, {6'h21, 3'h1, r});
    open_exp[1] = 1'b1;
    chk_open();
    repeat (8) @(negedge i_mclk);
    chk("queue_left", 24'h0, 24'(exp_q.size()));
    end_sim();
  end
endmodule // dat_activate_refresh_timing_tb_top
